// ==== hdl/xps_pkg.sv ====
// Constants and types shared by the crosspoint switch configuration loader
package xps_pkg;

  localparam int XPS_NUM_OUTPUTS = 16;
  localparam int XPS_NUM_INPUTS = 16;
  localparam int XPS_SEL_W = 4;
  localparam int XPS_ENTRY_W = 5;
  localparam int XPS_CHAIN_LEN = 80;
  localparam int XPS_ENTRY_EN_POS = 4;
  localparam int XPS_SYNC_STAGES = 2;

  // One output entry: enable on top, input number below
  typedef struct packed {
    logic output_enable_bit;
    logic [XPS_SEL_W-1:0] input_index;
  } xps_entry_t;

  typedef xps_entry_t [XPS_NUM_OUTPUTS-1:0] xps_config_t;

  // Control pins of the external controller
  typedef struct packed {
    logic link_clk;
    logic chip_select_n;
    logic update_n;
    logic serial_data_in;
    logic load_mode_select;
    logic output_disable_n;
    logic [XPS_SEL_W-1:0] output_index;
    xps_entry_t parallel_data;
  } xps_pins_t;

  localparam logic [XPS_CHAIN_LEN-1:0] XPS_CHAIN_RST = 80'h0000_0000_0000_0000_0000;
  localparam logic [XPS_NUM_INPUTS-1:0] XPS_ONE_HOT_BASE = 16'h0001;
  localparam logic [XPS_NUM_INPUTS-1:0] XPS_NO_INPUT = 16'h0000;
  localparam logic [XPS_NUM_OUTPUTS-1:0] XPS_ALL_OFF = 16'h0000;

endpackage

// ==== hdl/xps_sync.sv ====
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module xps_sync
  import xps_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output var logic [WIDTH-1:0] sync_out
);

  generate
    if (WIDTH < 1)
    begin : g_bad
      $error("xps_sync WIDTH must be at least 1");
    end
  endgenerate

  // Per bit: first stage feeds only the second
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++)
    begin : g_bit
      logic meta_r;
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          meta_r <= 1'b0;
          sync_out[b] <= 1'b0;
        end
        else if (clk_en)
        begin
          meta_r <= async_in[b];
          sync_out[b] <= meta_r;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ==== hdl/xps_loader.sv ====
// Two-rank configuration loader of a 16x16 crosspoint switch
`timescale 1ns/1ps
`default_nettype none
module xps_loader
  import xps_pkg::*;
#(
  parameter int NUM_OUTPUTS = XPS_NUM_OUTPUTS
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic link_clk,
  input wire logic chip_select_n,
  input wire logic update_n,
  input wire logic serial_data_in,
  input wire logic load_mode_select,
  input wire logic output_disable_n,
  input wire logic [XPS_SEL_W-1:0] output_index,
  input wire xps_entry_t parallel_data,
  output var logic serial_data_out,
  output var xps_config_t switch_config,
  output var logic [XPS_NUM_OUTPUTS-1:0] analog_output_n_active,
  output var logic [XPS_NUM_OUTPUTS-1:0][XPS_NUM_INPUTS-1:0] crosspoint_connect
);

  // Elaboration check: the entry layout is fixed at sixteen outputs
  generate
    if (NUM_OUTPUTS != XPS_NUM_OUTPUTS)
    begin : g_bad
      $error("xps_loader supports only NUM_OUTPUTS = 16");
    end
  endgenerate

  xps_pins_t pins_raw;
  xps_pins_t pins_s;
  logic link_clk_d_r;
  logic clk_fall;
  logic load_ok;
  logic latch_open;
  logic [XPS_CHAIN_LEN-1:0] chain_r;
  logic [XPS_CHAIN_LEN-1:0] chain_nxt;
  xps_config_t latch_r;

  // Gather the pins into one bundle
  always_comb
  begin
    pins_raw.link_clk = link_clk;
    pins_raw.chip_select_n = chip_select_n;
    pins_raw.update_n = update_n;
    pins_raw.serial_data_in = serial_data_in;
    pins_raw.load_mode_select = load_mode_select;
    pins_raw.output_disable_n = output_disable_n;
    pins_raw.output_index = output_index;
    pins_raw.parallel_data = parallel_data;
  end

  // All pins cross into the ref_clk domain
  xps_sync #(
    .WIDTH($bits(xps_pins_t))
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  // Delayed copy of the synchronised control clock
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      link_clk_d_r <= 1'b0;
    else if (clk_en)
      link_clk_d_r <= pins_s.link_clk;
  end

  // Falling control clock edge
  assign clk_fall = link_clk_d_r & ~pins_s.link_clk;
  // Loading needs select low and update high
  assign load_ok = clk_fall & ~pins_s.chip_select_n & pins_s.update_n;
  // Second rank open while select and update are both low
  assign latch_open = ~pins_s.chip_select_n & ~pins_s.update_n;

  // Next first-rank value for serial shift or indexed parallel write
  always_comb
  begin
    chain_nxt = chain_r;
    if (!pins_s.load_mode_select)
    begin
      // New bit enters at bit 0, oldest leaves from the top
      chain_nxt = {chain_r[XPS_CHAIN_LEN-2:0], pins_s.serial_data_in};
    end
    else
    begin
      // Entry k occupies bits 5k+4 .. 5k, enable on top
      chain_nxt[pins_s.output_index*XPS_ENTRY_W +: XPS_ENTRY_W] =
        pins_s.parallel_data;
    end
  end

  // First rank updates only on qualified falling edges
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      chain_r <= XPS_CHAIN_RST;
    else if (clk_en && load_ok)
      chain_r <= chain_nxt;
  end

  // Second rank follows while open, holds otherwise; one latch for all
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      latch_r <= xps_config_t'(XPS_CHAIN_RST);
    else if (clk_en && latch_open)
      latch_r <= xps_config_t'(chain_r);
  end

  // Chain tail drives the daisy-chain output, registered from the top bit in both load modes
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      serial_data_out <= 1'b0;
    else if (clk_en)
      serial_data_out <= chain_r[XPS_CHAIN_LEN-1];
  end

  // Visible switch state straight from the second rank
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      switch_config <= xps_config_t'(XPS_CHAIN_RST);
    else if (clk_en)
      switch_config <= latch_r;
  end

  // Per output: drive enable and one-hot input connection
  genvar o;
  generate
    for (o = 0; o < XPS_NUM_OUTPUTS; o++)
    begin : g_out
      logic active;
      // Disable pin overrides the latched enable, latch itself untouched
      assign active = latch_r[o].output_enable_bit & pins_s.output_disable_n;
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          analog_output_n_active[o] <= 1'b0;
          crosspoint_connect[o] <= XPS_NO_INPUT;
        end
        else if (clk_en)
        begin
          analog_output_n_active[o] <= active;
          if (active)
            crosspoint_connect[o] <= XPS_ONE_HOT_BASE << latch_r[o].input_index;
          else
            crosspoint_connect[o] <= XPS_NO_INPUT;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ==== sim/xps_loader_asserts.sv ====
// Pin-level assertions for the crosspoint loader
`timescale 1ns/1ps
`default_nettype none
module xps_loader_asserts
  import xps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic chip_select_n,
  input wire logic update_n,
  input wire logic output_disable_n,
  input wire logic serial_data_out,
  input wire xps_config_t switch_config,
  input wire logic [XPS_NUM_OUTPUTS-1:0] analog_output_n_active
);
  logic open_v;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Second rank open at the pins
  assign open_v = !chip_select_n && !update_n;
  property p_cs;
    chip_select_n [*5] |=> $stable({switch_config, serial_data_out});
  endproperty
  a_cs: assert property (p_cs) else $error("moved while deselected");
  property p_upd;
    update_n [*5] |=> $stable(switch_config);
  endproperty
  a_upd: assert property (p_upd) else $error("config moved while held");
  property p_noshift;
    !update_n [*5] |=> $stable(serial_data_out);
  endproperty
  a_noshift: assert property (p_noshift) else $error("shift while open");
  property p_dis;
    !output_disable_n [*5] |-> analog_output_n_active == XPS_ALL_OFF;
  endproperty
  a_dis: assert property (p_dis) else $error("output on while disabled");
  property p_glob;
    (update_n && output_disable_n) [*5] |=> $stable(analog_output_n_active);
  endproperty
  a_glob: assert property (p_glob) else $error("outputs moved while held");
  property p_rst;
    $fell(rst) |-> switch_config == '0 && analog_output_n_active == XPS_ALL_OFF;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs live after reset");
  property p_cfg;
    $changed(switch_config) |-> $past(open_v, 2) || $past(open_v, 3) || $past(open_v, 4);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config moved without update");
  property p_sout;
    $changed(serial_data_out) |->
      !($past(link_clk, 2) && $past(link_clk, 3) && $past(link_clk, 4));
  endproperty
  a_sout: assert property (p_sout) else $error("shift without link fall");
endmodule
bind xps_loader xps_loader_asserts chk_i (.*);
`default_nettype wire

// ==== sim/xps_ctrl_model.sv ====
// Controller model clocking bits in
`timescale 1ns/1ps
`default_nettype none
module xps_ctrl_model
(
  output var logic link_clk,
  output var logic serial_data_in
);
  // Link clock parked high between frames
  initial
  begin
    link_clk = 1'b1;
    serial_data_in = 1'b0;
  end
  // Sends top n bits of w, highest first
  task automatic send(input logic [79:0] w, input int n);
    for (int i = 79; i > 79 - n; i--)
    begin
      serial_data_in = w[i];
      #160 link_clk = 1'b0;
      #160 link_clk = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// ==== sim/test_xps_loader.sv ====
// Self-checking bench for the crosspoint loader
`timescale 1ns/1ps
`default_nettype none
module test_xps_loader
  import xps_pkg::*;
;
  localparam logic [79:0] W = 80'hA5C3_0F96_3C5A_7E81_D24B;
  localparam logic [79:0] P = {5'h0A, W[74:5], 5'h1F};
  logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, chip_select_n = 1'b1, update_n = 1'b1;
  logic load_mode_select = 1'b0, output_disable_n = 1'b1, link_clk, serial_data_in;
  logic serial_data_out;
  logic [3:0] output_index = 4'h0;
  xps_entry_t parallel_data = 5'h00;
  xps_config_t switch_config;
  logic [15:0] analog_output_n_active;
  logic [15:0][15:0] crosspoint_connect;
  int bad_count = 0, n_compared = 0;
  xps_loader dut (.*);
  xps_ctrl_model ctrl (.*);
  always #20 ref_clk = ~ref_clk;
  // Enable bits of all entries
  function automatic logic [15:0] en_of(input logic [79:0] w);
    for (int o = 0; o < 16; o++)
      en_of[o] = w[5*o+4];
  endfunction
  task automatic chk(input logic [79:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic upd();
    update_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    update_n = 1'b1;
    repeat (8) @(negedge ref_clk);
  endtask
  task automatic t_serial();
    chip_select_n = 1'b0;
    ctrl.send(W, 79);
    repeat (6) @(negedge ref_clk);
    chk(serial_data_out, 1'h0);
    ctrl.send(W << 79, 1);
    repeat (6) @(negedge ref_clk);
    chk(serial_data_out, 1'h1);
    chk(switch_config, '0);
    upd();
    chk(switch_config, W);
    chk(analog_output_n_active, en_of(W));
  endtask
  task automatic t_cs();
    chip_select_n = 1'b1;
    ctrl.send(~W, 80);
    upd();
    chip_select_n = 1'b0;
    upd();
    chk(switch_config, W);
  endtask
  task automatic t_par();
    load_mode_select = 1'b1;
    output_index = 4'hF;
    parallel_data = 5'h0A;
    ctrl.send(W, 1);
    output_index = 4'h0;
    parallel_data = 5'h1F;
    ctrl.send(W, 1);
    chk(switch_config, W);
    upd();
    chk(switch_config, P);
    chk(crosspoint_connect[0], 16'h8000);
  endtask
  task automatic t_dis();
    output_disable_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk(analog_output_n_active, '0);
    chk(switch_config, P);
    output_disable_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk(analog_output_n_active, en_of(P));
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    t_serial();
    t_cs();
    t_par();
    t_dis();
    summarize();
  end
endmodule
`default_nettype wire
